// *** design/ssrl_pkg.sv ***
// Package: constants and carrier types for the serial register load block
`default_nettype none
package ssrl_pkg;
   // Word layout
   localparam int WORD_W     = 24;
   localparam int NUM_LATCH  = 8;
   localparam int SEL_W      = 3;
   localparam int SELECT_LSB = 1;
   localparam int SELECT_MSB = 3;
   localparam int MODE_BIT   = 0;
   localparam logic [SEL_W-1:0] SEL_FEEDBACK = 3'h0;
   localparam logic [SEL_W-1:0] SEL_DENOM    = 3'h1;
   localparam logic [SEL_W-1:0] SEL_MODE     = 3'h4;
   localparam logic [SEL_W-1:0] SEL_EXT      = 3'h5;
   localparam logic [SEL_W-1:0] SEL_TIMING   = 3'h6;
   localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;

   // Feedback divider word fields
   localparam int FB_N_MSB  = 23;
   localparam int FB_N_LSB  = 13;
   localparam int FB_FN_MSB = 12;
   localparam int FB_FN_LSB = 1;
   // Denominator and reference word fields
   localparam int DN_PSEL    = 22;
   localparam int DN_R_MSB   = 21;
   localparam int DN_R_LSB   = 16;
   localparam int DN_FD_MSB  = 15;
   localparam int DN_FD_LSB  = 4;
   // Extension word fields
   localparam int EX_FD_MSB = 23;
   localparam int EX_FD_LSB = 14;
   localparam int EX_FN_MSB = 13;
   localparam int EX_FN_LSB = 4;
   // Mode word and timing word fields
   localparam int MD_ORD_MSB = 15;
   localparam int MD_ORD_LSB = 14;
   localparam int TM_TC_MSB  = 17;
   localparam int TM_TC_LSB  = 4;
   localparam int TC_W       = 14;
   // Feedback divide split
   localparam int C_MSB = 10;
   localparam int C_LSB = 5;
   localparam int B_MSB = 4;
   localparam int B_LSB = 2;
   localparam int A_MSB = 1;
   localparam int A_LSB = 0;
   localparam int DIV_W = 12;
   localparam logic [DIV_W-1:0] BASE_SMALL = 12'h010;
   localparam logic [DIV_W-1:0] BASE_LARGE = 12'h020;
   localparam logic [DIV_W-1:0] MID_WEIGHT = 12'h004;

   typedef logic [NUM_LATCH-1:0][WORD_W-1:0] ssrl_latch_array_t;

   // Decoded RF settings, registered
   typedef struct packed {
      logic [10:0]      rf_feedback_divide;
      logic [21:0]      rf_fraction_numerator;
      logic [21:0]      rf_fraction_denominator;
      logic [5:0]       rf_reference_divide;
      logic             rf_prescaler_select;
      logic [1:0]       modulator_order;
      logic [5:0]       rf_coarse_count;
      logic [2:0]       rf_mid_count;
      logic [1:0]       rf_fine_count;
      logic [DIV_W-1:0] rf_divide_value;
   } ssrl_rf_settings_t;
endpackage : ssrl_pkg
`default_nettype wire

// *** design/ssrl_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module ssrl_pin_sync (
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   output var  logic level_o
);
   logic stage1;
   logic stage2;
   logic stage3;

   // Level only moves once the two settled stages agree
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         stage1  <= 1'b0;
         stage2  <= 1'b0;
         stage3  <= 1'b0;
         level_o <= 1'b0;
      end else begin
         stage1 <= pin_i;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level_o <= stage3;
         end
      end
   end
endmodule : ssrl_pin_sync
`default_nettype wire

// *** design/ssrl_word_latch.sv ***
// One programming latch: holds its word until written
`default_nettype none
module ssrl_word_latch #(
   parameter int                WIDTH      = 24,
   parameter logic [WIDTH-1:0]  RESET_WORD = '0
) (
   input  wire logic             sys_clk_i,
   input  wire logic             reset_i,
   input  wire logic             write_i,
   input  wire logic [WIDTH-1:0] word_i,
   output var  logic [WIDTH-1:0] word_o
);
   // Unselected latches simply hold
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         word_o <= RESET_WORD;
      end else if (write_i) begin
         word_o <= word_i;
      end
   end
endmodule : ssrl_word_latch
`default_nettype wire

// *** design/ssrl_serial_load.sv ***
// Serial programming front end: shift register, latch decode, counter reinit
//
// Overview of operation
// [RULE_01] Words are 24 bits, shifted in first
// [RULE_02] Most significant bit arrives first, bit 0 last
// [RULE_03] Strobe rising edge copies word into one latch
// [RULE_04] Low four bits address, upper bits payload
// [RULE_05] Bit 0 clear always targets latch zero
// [RULE_06] Bit 0 set: bits 3..1 pick latches 1-7; the code also sends bits 3..1 of 000 to latch zero
// [RULE_07] Writing latch zero reinitialises lock and acquire
// [RULE_08] Reinit clears counters only, never latch contents
// [RULE_09] Host should write latch zero last
// [RULE_10] Host may skip latch seven without extended fraction; the code reads the extension word from latch five
// [RULE_11] Divide equals base times C plus 4B plus A
// [RULE_12] Host keeps C at least max of A, B
// [RULE_13] Small prescaler: host keeps divide 49 to 1023
// [RULE_14] Two selectable quad-modulus prescaler bases
// [RULE_15] Latch zero holds divide over fraction numerator low
// [RULE_16] Host bring-up: third order, 12-bit, no dither
// [RULE_17] Select bit clear small prescaler, set large
// [RULE_18] Data sampled on serial clock rise, strobe low
// [RULE_19] Unselected latches keep contents on strobe rise
`default_nettype none
module ssrl_serial_load #(
   parameter int LOCK_COUNT = 32
) (
   input  wire logic                         sys_clk_i,
   input  wire logic                         reset_i,
   input  wire logic                         serial_clock_i,
   input  wire logic                         serial_data_i,
   input  wire logic                         load_strobe_i,
   input  wire logic                         compare_tick_i,
   input  wire logic                         phase_in_window_i,
   output var  ssrl_pkg::ssrl_latch_array_t  latch_words_o,
   output var  ssrl_pkg::ssrl_rf_settings_t  rf_settings_o,
   output var  logic                         counters_reinit_o,
   output var  logic                         fast_acquire_active_o,
   output var  logic                         lock_detect_o
);
   localparam int LOCK_W = $clog2(LOCK_COUNT + 1);
   localparam logic [LOCK_W-1:0] LOCK_TOP = LOCK_W'(LOCK_COUNT);

   logic                                 sclk_lvl;
   logic                                 sdata_lvl;
   logic                                 strobe_lvl;
   logic                                 sclk_q;
   logic                                 strobe_q;
   logic [ssrl_pkg::WORD_W-1:0]          shift_reg;
   logic [ssrl_pkg::TC_W-1:0]            fast_count;
   logic [LOCK_W-1:0]                    lock_count;
   logic [ssrl_pkg::NUM_LATCH-1:0]       wr_en;
   ssrl_pkg::ssrl_rf_settings_t          next_settings;

   // Pin synchronisers. A change counts only once two settled stages agree,
   // so a pin must hold each level for two clocks or more; the link
   // therefore runs far below the system clock.
   ssrl_pin_sync u_sync_clk (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pin_i     (serial_clock_i),
      .level_o   (sclk_lvl)
   );
   ssrl_pin_sync u_sync_data (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pin_i     (serial_data_i),
      .level_o   (sdata_lvl)
   );
   ssrl_pin_sync u_sync_strobe (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pin_i     (load_strobe_i),
      .level_o   (strobe_lvl)
   );

   // Edge detection on filtered levels; data and clock share latency
   wire sclk_rise = sclk_lvl & ~sclk_q;
   wire shift_en  = sclk_rise & ~strobe_lvl;                 // RULE_18
   wire load_rise = strobe_lvl & ~strobe_q;                  // RULE_03

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sclk_q   <= 1'b0;
         strobe_q <= 1'b0;
      end else begin
         sclk_q   <= sclk_lvl;
         strobe_q <= strobe_lvl;
      end
   end

   // Shift register, first bit ends up at the top. There is no bit counter:
   // an overlong frame pushes its early bits out and the last 24 count.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         shift_reg <= ssrl_pkg::LATCH_RESET;
      end else if (shift_en) begin
         shift_reg <= {shift_reg[ssrl_pkg::WORD_W-2:0], sdata_lvl};  // RULE_01 RULE_02
      end
   end

   // Address decode: bit 0 clear is the single-word feedback write, which
   // leaves 23 payload bits for a one-write frequency change.
   wire                            mode_bit  = shift_reg[ssrl_pkg::MODE_BIT];      // RULE_04
   wire [ssrl_pkg::SEL_W-1:0]      sel_bits  =
      shift_reg[ssrl_pkg::SELECT_MSB:ssrl_pkg::SELECT_LSB];
   wire [ssrl_pkg::SEL_W-1:0]      sel_index =
      mode_bit ? sel_bits : ssrl_pkg::SEL_FEEDBACK;                              // RULE_05 RULE_06

   // Latch bank, one write enable each
   genvar gi;
   generate
      for (gi = 0; gi < ssrl_pkg::NUM_LATCH; gi++) begin : g_latch
         assign wr_en[gi] = load_rise && (sel_index == ssrl_pkg::SEL_W'(gi));      // RULE_03 RULE_19
         ssrl_word_latch #(
            .WIDTH      (ssrl_pkg::WORD_W),
            .RESET_WORD (ssrl_pkg::LATCH_RESET)
         ) u_latch (
            .sys_clk_i (sys_clk_i),
            .reset_i   (reset_i),
            .write_i   (wr_en[gi]),
            .word_i    (shift_reg),
            .word_o    (latch_words_o[gi])
         );
      end
   endgenerate

   // Field extraction from the latched words
   wire [ssrl_pkg::WORD_W-1:0] fb_word  = latch_words_o[ssrl_pkg::SEL_FEEDBACK];
   wire [ssrl_pkg::WORD_W-1:0] dn_word  = latch_words_o[ssrl_pkg::SEL_DENOM];
   wire [ssrl_pkg::WORD_W-1:0] ex_word  = latch_words_o[ssrl_pkg::SEL_EXT];
   wire [ssrl_pkg::WORD_W-1:0] md_word  = latch_words_o[ssrl_pkg::SEL_MODE];
   wire [ssrl_pkg::WORD_W-1:0] tm_word  = latch_words_o[ssrl_pkg::SEL_TIMING];
   wire [10:0] fb_n   = fb_word[ssrl_pkg::FB_N_MSB:ssrl_pkg::FB_N_LSB];            // RULE_15
   wire [11:0] fb_fn  = fb_word[ssrl_pkg::FB_FN_MSB:ssrl_pkg::FB_FN_LSB];          // RULE_15
   wire [5:0]  c_cnt  = fb_n[ssrl_pkg::C_MSB:ssrl_pkg::C_LSB];                     // RULE_11
   wire [2:0]  b_cnt  = fb_n[ssrl_pkg::B_MSB:ssrl_pkg::B_LSB];
   wire [1:0]  a_cnt  = fb_n[ssrl_pkg::A_MSB:ssrl_pkg::A_LSB];
   wire        p_sel  = dn_word[ssrl_pkg::DN_PSEL];
   wire [ssrl_pkg::DIV_W-1:0] p_base =
      p_sel ? ssrl_pkg::BASE_LARGE : ssrl_pkg::BASE_SMALL;                        // RULE_14 RULE_17
   wire [ssrl_pkg::DIV_W-1:0] div_value =
      ssrl_pkg::DIV_W'(p_base * c_cnt) + ssrl_pkg::DIV_W'(ssrl_pkg::MID_WEIGHT * b_cnt)
      + ssrl_pkg::DIV_W'(a_cnt);                                                  // RULE_11
   wire [ssrl_pkg::TC_W-1:0] tc_value = tm_word[ssrl_pkg::TM_TC_MSB:ssrl_pkg::TM_TC_LSB];

   // Settings bundle, assembled then registered
   always_comb begin
      next_settings                         = '0;
      next_settings.rf_feedback_divide      = fb_n;
      next_settings.rf_fraction_numerator   =
         {ex_word[ssrl_pkg::EX_FN_MSB:ssrl_pkg::EX_FN_LSB], fb_fn};
      next_settings.rf_fraction_denominator =
         {ex_word[ssrl_pkg::EX_FD_MSB:ssrl_pkg::EX_FD_LSB],
          dn_word[ssrl_pkg::DN_FD_MSB:ssrl_pkg::DN_FD_LSB]};
      next_settings.rf_reference_divide     = dn_word[ssrl_pkg::DN_R_MSB:ssrl_pkg::DN_R_LSB];
      next_settings.rf_prescaler_select     = p_sel;
      next_settings.modulator_order         = md_word[ssrl_pkg::MD_ORD_MSB:ssrl_pkg::MD_ORD_LSB];
      next_settings.rf_coarse_count         = c_cnt;
      next_settings.rf_mid_count            = b_cnt;
      next_settings.rf_fine_count           = a_cnt;
      next_settings.rf_divide_value         = div_value;
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rf_settings_o <= '0;
      end else begin
         rf_settings_o <= next_settings;
      end
   end

   // Reinit pulse follows any feedback-latch write, one cycle later
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         counters_reinit_o <= 1'b0;
      end else begin
         counters_reinit_o <= wr_en[ssrl_pkg::SEL_FEEDBACK];                      // RULE_07
      end
   end

   // Fast-acquire timeout: reload on reinit, count comparison ticks down.
   // Only the counter moves; the latched timeout value stays put.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         fast_count <= '0;
      end else if (counters_reinit_o) begin
         fast_count <= tc_value;                                                  // RULE_07 RULE_08
      end else if (compare_tick_i && (fast_count != '0)) begin
         fast_count <= fast_count - 1'b1;
      end
   end

   // Lock detector: consecutive in-window comparisons, saturating
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         lock_count <= '0;
      end else if (counters_reinit_o) begin
         lock_count <= '0;                                                        // RULE_07 RULE_08
      end else if (compare_tick_i) begin
         if (!phase_in_window_i) begin
            lock_count <= '0;
         end else if (lock_count != LOCK_TOP) begin
            lock_count <= lock_count + 1'b1;
         end
      end
   end

   // Status pins come from flops so a counter decode never glitches outward;
   // the price is one more cycle of lag behind the counters.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         fast_acquire_active_o <= 1'b0;
         lock_detect_o         <= 1'b0;
      end else begin
         fast_acquire_active_o <= (fast_count != '0);                             // RULE_07
         lock_detect_o         <= (lock_count == LOCK_TOP);                       // RULE_07
      end
   end

   // Helper copies of each load for the checks below,
   // kept apart from the datapath so the checks see one load at a time
   logic                                 load_q;
   logic [ssrl_pkg::SEL_W-1:0]           sel_q;
   logic [ssrl_pkg::WORD_W-1:0]          word_q;
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         load_q <= 1'b0;
         sel_q  <= '0;
         word_q <= '0;
      end else begin
         load_q <= load_rise;
         sel_q  <= sel_index;
         word_q <= shift_reg;
      end
   end
   wire [ssrl_pkg::NUM_LATCH*ssrl_pkg::WORD_W-1:0] latch_flat = latch_words_o;
   wire [ssrl_pkg::NUM_LATCH*ssrl_pkg::WORD_W-1:0] keep_mask  =
      ~({{(ssrl_pkg::NUM_LATCH-1)*ssrl_pkg::WORD_W{1'b0}}, {ssrl_pkg::WORD_W{1'b1}}}
        << (sel_q * ssrl_pkg::WORD_W));

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   shift_order_a: assert property (shift_en |=>                                   // RULE_02
      shift_reg == {$past(shift_reg[ssrl_pkg::WORD_W-2:0]), $past(sdata_lvl)})
      else $error("shift register did not take data at the bottom");
   strobe_hold_a: assert property (strobe_lvl |=> $stable(shift_reg))             // RULE_18
      else $error("shift register moved while strobe high");
   load_target_a: assert property (load_q |-> latch_words_o[sel_q] == word_q)     // RULE_03
      else $error("selected latch did not receive the word");
   zero_route_a: assert property (load_rise && !mode_bit |=>                      // RULE_05
      latch_words_o[ssrl_pkg::SEL_FEEDBACK] == $past(shift_reg))
      else $error("bit 0 clear word missed latch zero");
   others_keep_a: assert property (load_q |->                                     // RULE_19
      (latch_flat & keep_mask) == ($past(latch_flat) & keep_mask))
      else $error("unselected latch changed on load");
   idle_keep_a: assert property (!load_rise |=> $stable(latch_flat))              // RULE_08
      else $error("latch changed without a load");
   reinit_pulse_a: assert property (load_rise && sel_index == ssrl_pkg::SEL_FEEDBACK  // RULE_07
      |=> counters_reinit_o ##1 ((lock_count == '0) && (fast_count == $past(tc_value))))
      else $error("feedback write did not reinitialise counters");
   reinit_cause_a: assert property (counters_reinit_o |->                         // RULE_07
      $past(load_rise) && $past(sel_index) == ssrl_pkg::SEL_FEEDBACK)
      else $error("reinit without a feedback write");
   divide_calc_a: assert property (rf_settings_o.rf_divide_value ==               // RULE_11
      (rf_settings_o.rf_prescaler_select ? ssrl_pkg::BASE_LARGE : ssrl_pkg::BASE_SMALL)
         * rf_settings_o.rf_coarse_count
      + ssrl_pkg::MID_WEIGHT * rf_settings_o.rf_mid_count + rf_settings_o.rf_fine_count)
      else $error("divide value inconsistent with counts");

   // Decode, counter, shift and settings checks
   sel_decode_a: assert property (load_q && word_q[ssrl_pkg::MODE_BIT] |->          // RULE_06
      latch_words_o[word_q[ssrl_pkg::SELECT_MSB:ssrl_pkg::SELECT_LSB]] == word_q)
      else $error("bit 0 set word missed its numbered latch");
   reinit_only_a: assert property (load_rise && sel_index != ssrl_pkg::SEL_FEEDBACK  // RULE_07
      |=> !counters_reinit_o)
      else $error("reinit after a write to another latch");
   reinit_width_a: assert property (counters_reinit_o |=> !counters_reinit_o)       // RULE_07
      else $error("reinit pulse longer than one cycle");
   fast_step_a: assert property (compare_tick_i && !counters_reinit_o              // RULE_07
      && (fast_count != '0) |=> fast_count == $past(fast_count) - 1'b1)
      else $error("fast-acquire count did not step down");
   lock_drop_a: assert property (compare_tick_i && !phase_in_window_i              // RULE_07
      && !counters_reinit_o |=> lock_count == '0)
      else $error("lock count survived an out-of-window comparison");
   lock_hold_a: assert property (!compare_tick_i && !counters_reinit_o             // RULE_08
      |=> $stable(lock_count))
      else $error("lock count moved without a tick or reinit");
   shift_idle_a: assert property (!shift_en |=> $stable(shift_reg))                 // RULE_18
      else $error("shift register moved without a serial clock rise");
   settings_copy_a: assert property (1'b1 |=>                                       // RULE_15
      rf_settings_o.rf_feedback_divide == $past(fb_n))
      else $error("feedback divide not copied from latch zero");
   prescale_copy_a: assert property (1'b1 |=>                                       // RULE_17
      rf_settings_o.rf_prescaler_select == $past(dn_word[ssrl_pkg::DN_PSEL]))
      else $error("prescaler select not taken from the denominator latch");

   // Main scenarios: feedback write, last latch, lock gained and lost, large base
   feedback_load_c: cover property (load_rise && !mode_bit);
   last_latch_c:    cover property (load_rise && mode_bit && (&sel_bits));
   lock_reached_c:  cover property (counters_reinit_o ##[1:200] lock_detect_o);
   lock_lost_c:     cover property (lock_detect_o && compare_tick_i && !phase_in_window_i);
   large_base_c:    cover property (counters_reinit_o && rf_settings_o.rf_prescaler_select);
endmodule : ssrl_serial_load
`default_nettype wire

// *** test/ssrl_host_model.sv ***
// Host model that drives the three-wire programming link
`default_nettype none
module ssrl_host_model (
   output var logic serial_clock_o,
   output var logic serial_data_o,
   output var logic load_strobe_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // Half of the 125 ns link period; raise it to model a slow host
   real half_ns = 62.5;

   // Pins start low; the clock stands still outside frames
   initial begin
      serial_clock_o = 1'b0;
      serial_data_o  = 1'b0;
      load_strobe_o  = 1'b0;
   end

   // Shift n bits MSB first, then strobe; extra clocks while strobe is high
   task automatic send_bits(input logic [31:0] w, input int n, input int extra);
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_o = w[i];
         #(half_ns) serial_clock_o = 1'b1;
         #(half_ns) serial_clock_o = 1'b0;
      end
      // Released data flips so a stale bit can never look valid
      serial_data_o = ~serial_data_o;
      #(half_ns) load_strobe_o = 1'b1;
      repeat (extra) begin
         serial_data_o = ~serial_data_o;
         #(half_ns) serial_clock_o = 1'b1;
         #(half_ns) serial_clock_o = 1'b0;
      end
      #(half_ns) load_strobe_o = 1'b0;
   endtask : send_bits
endmodule : ssrl_host_model
`default_nettype wire

// *** test/ssrl_serial_load_tb_top.sv ***
// Self-checking testbench for the serial register load block
`default_nettype none
module ssrl_serial_load_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   logic                        sys_clk = 1'b0;
   logic                        reset   = 1'b1;
   logic                        tick    = 1'b0;
   logic                        in_win  = 1'b1;
   wire logic                   sclk;
   wire logic                   sdata;
   wire logic                   strobe;
   ssrl_pkg::ssrl_latch_array_t lat;
   ssrl_pkg::ssrl_rf_settings_t rf_set;
   logic                        reinit;
   logic                        fast;
   logic                        lock;
   logic [23:0]                 exp_lat [8];
   int                          n_mismatch = 0;
   int                          n_tests    = 0;
   int                          n_reinit   = 0;
   int                          exp_reinit = 0;

   // 250 MHz system clock
   always #2 sys_clk = ~sys_clk;

   ssrl_host_model i_host (
      .serial_clock_o (sclk),
      .serial_data_o  (sdata),
      .load_strobe_o  (strobe)
   );

   // Small lock count keeps the lock scenario short
   ssrl_serial_load #(.LOCK_COUNT(4)) i_dut (
      .sys_clk_i             (sys_clk),
      .reset_i               (reset),
      .serial_clock_i        (sclk),
      .serial_data_i         (sdata),
      .load_strobe_i         (strobe),
      .compare_tick_i        (tick),
      .phase_in_window_i     (in_win),
      .latch_words_o         (lat),
      .rf_settings_o         (rf_set),
      .counters_reinit_o     (reinit),
      .fast_acquire_active_o (fast),
      .lock_detect_o         (lock)
   );

   // Count reinit pulses, since they stand for one cycle only
   always @(posedge sys_clk) begin
      if (reinit === 1'b1) n_reinit <= n_reinit + 1;
   end

   task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_flag(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_flag

   task automatic chk_set(input ssrl_pkg::ssrl_rf_settings_t got,
                          input ssrl_pkg::ssrl_rf_settings_t exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: settings got %h expected %h", $time, got, exp);
      end
   endtask : chk_set

   // Decoded settings worked out from the expected latch words
   function automatic ssrl_pkg::ssrl_rf_settings_t exp_set();
      ssrl_pkg::ssrl_rf_settings_t e;
      logic [11:0]                 base;
      e.rf_feedback_divide      = exp_lat[0][23:13];
      e.rf_fraction_numerator   = {exp_lat[5][13:4], exp_lat[0][12:1]};
      e.rf_fraction_denominator = {exp_lat[5][23:14], exp_lat[1][15:4]};
      e.rf_reference_divide     = exp_lat[1][21:16];
      e.rf_prescaler_select     = exp_lat[1][22];
      e.modulator_order         = exp_lat[4][15:14];
      e.rf_coarse_count         = e.rf_feedback_divide[10:5];
      e.rf_mid_count            = e.rf_feedback_divide[4:2];
      e.rf_fine_count           = e.rf_feedback_divide[1:0];
      base = e.rf_prescaler_select ? 12'h020 : 12'h010;
      e.rf_divide_value = base * {6'h00, e.rf_coarse_count}
                        + 12'h004 * {9'h000, e.rf_mid_count}
                        + {10'h000, e.rf_fine_count};
      return e;
   endfunction : exp_set

   // Let synchroniser, latch and settings stages land
   task automatic settle();
      repeat (20) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic send(input logic [23:0] w);
      i_host.send_bits({8'h00, w}, 24, 0);
      exp_lat[w[0] ? w[3:1] : 3'h0] = w;
      if (w[0] == 1'b0) exp_reinit++;
      settle();
   endtask : send

   task automatic check_all();
      for (int i = 0; i < 8; i++) chk_word(lat[i], exp_lat[i], "latch word");
      chk_word(24'(n_reinit), 24'(exp_reinit), "reinit pulses");
   endtask : check_all

   task automatic pulse_tick(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         #1 tick = 1'b1;
         @(posedge sys_clk);
         #1 tick = 1'b0;
      end
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : pulse_tick

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   // Main sequence; the feedback word is written after the others
   initial begin
      logic [23:0] w;
      for (int i = 0; i < 8; i++) exp_lat[i] = 24'h000000;
      repeat (12) @(posedge sys_clk);
      #1 reset = 1'b0;
      settle();
      check_all();
      chk_set(rf_set, exp_set());
      for (int i = 1; i < 8; i++) begin
         send({20'h96c3a + 20'(i) * 20'h11111, 3'(i), 1'b1});
         check_all();
      end
      send({6'h00, 14'h0003, 4'hd});
      // Bits 3..1 nonzero but bit 0 clear; divide 343 is legal, C above A and B
      send({11'h2a7, 12'habc, 1'b0});
      check_all();
      chk_set(rf_set, exp_set());
      chk_flag(fast, 1'b1, "fast acquire after reinit");
      chk_flag(lock, 1'b0, "lock after reinit");
      pulse_tick(2);
      chk_flag(fast, 1'b1, "fast acquire midway");
      pulse_tick(1);
      chk_flag(fast, 1'b0, "fast acquire expired");
      chk_flag(lock, 1'b0, "lock too early");
      pulse_tick(1);
      chk_flag(lock, 1'b1, "lock reached");
      in_win = 1'b0;
      pulse_tick(1);
      chk_flag(lock, 1'b0, "lock lost out of window");
      in_win = 1'b1;
      pulse_tick(4);
      chk_flag(lock, 1'b1, "lock regained");
      send(exp_lat[1] ^ 24'h400000);
      chk_set(rf_set, exp_set());
      chk_flag(lock, 1'b1, "lock kept without feedback write");
      w = exp_lat[0];
      send(w);
      chk_flag(lock, 1'b0, "lock cleared by feedback write");
      chk_flag(fast, 1'b1, "fast acquire restarted");
      check_all();
      // Overlong frame: only the final 24 bits count
      w = {20'h3e1f0, 3'h2, 1'b1};
      i_host.send_bits({8'hf5, w}, 28, 0);
      exp_lat[2] = w;
      settle();
      check_all();
      // Clocks while the strobe is high must not shift
      i_host.send_bits(32'h00000000, 0, 4);
      // A bare second strobe latches whatever the register holds now
      i_host.send_bits(32'h00000000, 0, 0);
      settle();
      check_all();
      // Mid-run reset, then a short program that leaves latch seven unwritten
      reset = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 reset = 1'b0;
      for (int i = 0; i < 8; i++) exp_lat[i] = 24'h000000;
      settle();
      check_all();
      chk_flag(fast, 1'b0, "fast acquire after mid-run reset");
      send({20'h5a5a5, 3'h1, 1'b1});
      // Large prescaler, divide 336 with C above A and B
      send({11'h150, 12'h123, 1'b0});
      check_all();
      chk_set(rf_set, exp_set());
      chk_flag(fast, 1'b0, "fast acquire with cleared timeout");
      give_verdict();
   end

   // Watchdog well beyond the expected 47 us of traffic
   initial begin
      #200000;
      n_mismatch++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule : ssrl_serial_load_tb_top
`default_nettype wire
